/* File: logic/clock_gating_pkg.sv */
// Constants and types shared by the peripheral clock gating controller.
`default_nettype none
package clock_gating_pkg;
  localparam int ADDR_W = 12;
  localparam int UNITS = 4;
  localparam logic [11:0] RUN_GATE_OFF = 12'h100;
  localparam logic [11:0] SLEEP_GATE_OFF = 12'h110;
  localparam logic [11:0] DEEP_GATE_OFF = 12'h120;
  localparam logic [11:0] RUN_CFG_OFF = 12'h130;
  localparam logic [11:0] IRQ_STATUS_OFF = 12'h140;
  localparam logic [11:0] IRQ_MASK_OFF = 12'h144;
  localparam logic [31:0] GATE_RESET = 32'h00000040;
  localparam logic [31:0] GATE_WMASK = 32'h00110348;
  localparam logic [31:0] CFG_RESET = 32'h00000000;
  localparam int HIBERNATION_BIT = 6;
  localparam int WATCHDOG_BIT = 3;
  localparam int ADC_BIT = 16;
  localparam int PWM_BIT = 20;
  localparam int SPEED_LSB = 8;
  localparam int AUTO_GATING_BIT = 0;
  localparam int UNIT_HIBERNATION = 0;
  localparam int UNIT_WATCHDOG = 1;
  localparam int UNIT_ADC = 2;
  localparam int UNIT_PWM = 3;
  localparam logic [3:0] UNIT_EN_RESET = 4'h1;
  localparam logic [1:0] SPEED_125K = 2'h0;
  localparam logic [1:0] SPEED_250K = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_RUN = 3'h1;
  localparam logic [2:0] SEL_SLEEP = 3'h2;
  localparam logic [2:0] SEL_DEEP = 3'h3;
  localparam logic [2:0] SEL_CFG = 3'h4;
  localparam logic [2:0] SEL_STATUS = 3'h5;
  localparam logic [2:0] SEL_MASK = 3'h6;

  typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_DEEP} power_state_t;

  // Pulls the four unit enables out of a gating register word.
  function automatic logic [3:0] unit_bits(input logic [31:0] r);
    unit_bits = {r[PWM_BIT], r[ADC_BIT], r[WATCHDOG_BIT], r[HIBERNATION_BIT]};
  endfunction
endpackage
`default_nettype wire

/* File: logic/gate_if.sv */
// Enables, freeze and fault events passed between controller and access guard.
`timescale 1ns/1ps
`default_nettype none
interface gate_if;
  logic ce;
  logic [3:0] enable;
  logic [3:0] fault;
  modport ctl (output ce, output enable, input fault);
  modport guard (input ce, input enable, output fault);
endinterface
`default_nettype wire

/* File: logic/unit_clock_gate.sv */
// Glitch-free clock gate for one peripheral.
`timescale 1ns/1ps
`default_nettype none
module unit_clock_gate #(
  parameter logic RESET_EN = 1'b0
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic enable_in,
  output var logic enable_out,
  output logic gated_clk_out
);
  logic en_q;
  // Capturing on the falling edge keeps the enable stable while the clock is high.
  always_ff @(negedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      en_q <= RESET_EN;
    end else if (ce_in) begin
      en_q <= enable_in;
    end
  end
  assign enable_out = en_q;
  assign gated_clk_out = clk_in & en_q;
endmodule // unit_clock_gate
`default_nettype wire

/* File: logic/access_guard.sv */
// Answers peripheral accesses, faulting those aimed at an unclocked unit.
`timescale 1ns/1ps
`default_nettype none
module access_guard (
  input wire logic clk_in,
  input wire logic reset_n_in,
  gate_if.guard gate,
  input wire logic acc_valid_in,
  input wire logic [1:0] acc_unit_in,
  output var logic acc_ok_out,
  output var logic acc_fault_out
);
  logic hit;
  logic ok_q;
  logic fault_q;
  logic [3:0] fault_vec_q;
  assign hit = gate.enable[acc_unit_in];
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ok_q <= 1'b0;
      fault_q <= 1'b0;
      fault_vec_q <= 4'h0;
    end else if (gate.ce) begin
      ok_q <= acc_valid_in & hit;
      fault_q <= acc_valid_in & ~hit;
      fault_vec_q <= (acc_valid_in & ~hit) ? (4'h1 << acc_unit_in) : 4'h0;
    end
  end
  assign acc_ok_out = ok_q;
  assign acc_fault_out = fault_q;
  assign gate.fault = fault_vec_q;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_fault_on_gated: assert property (
    gate.ce && acc_valid_in && !gate.enable[acc_unit_in] |=> acc_fault_out && !acc_ok_out)
    else $error("access to unclocked unit not faulted");
  a_ok_on_clocked: assert property (
    gate.ce && acc_valid_in && gate.enable[acc_unit_in] |=> acc_ok_out && !acc_fault_out)
    else $error("access to clocked unit refused");
  c_fault_seen: cover property (acc_fault_out);
endmodule // access_guard
`default_nettype wire

/* File: logic/peripheral_clock_gating_ctl.sv */
// Peripheral clock gating controller with an AXI4-Lite register slave.
// Operation
// - Each gating bit is one peripheral's clock enable: one clocks it, zero stops it.
// - Accesses to a peripheral whose clock is gated off end in a bus fault.
// - Gating bits reset to zero unless a different reset value is given.
// - Separate gating registers for run, sleep and deep sleep power states.
// - Sleep and deep-sleep registers apply only while automatic gating is selected.
// - Speed field bits 9:8 pick 250K (1) or 125K (0); resets to 0.
// - The converter rate never exceeds the maximum, whatever is written.
// - Bit 6 gates the hibernation unit and resets to one.
// - Bit 3 gates the watchdog, resets to zero, faults accesses while clear.
// - Bit 16 gates converter 0, resets to zero, faults accesses while clear.
// - Reserved bits are read-only zero; software preserves them.
// - Run and sleep gating registers share one layout and reset to 0x00000040.
// - Deep-sleep register shares the layout, sits at 0x120, resets to 0x00000040.
`timescale 1ns/1ps
`default_nettype none
module peripheral_clock_gating_ctl #(
  parameter logic [1:0] MAX_SPEED = clock_gating_pkg::SPEED_250K
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [clock_gating_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [clock_gating_pkg::ADDR_W-1:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  input wire logic [1:0] power_state_in,
  input wire logic acc_valid_in,
  input wire logic [1:0] acc_unit_in,
  output logic acc_ok_out,
  output logic acc_fault_out,
  output logic [3:0] unit_clk_en_out,
  output logic [3:0] gated_clk_out,
  output logic [1:0] adc_rate_out,
  output logic irq_out
);
  gate_if gate ();

  logic aw_hold_q;
  logic w_hold_q;
  logic [clock_gating_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] run_gate_q;
  logic [31:0] sleep_gate_q;
  logic [31:0] deep_gate_q;
  logic [31:0] run_cfg_q;
  logic [3:0] irq_status_q;
  logic [3:0] irq_mask_q;
  logic [1:0] adc_rate_q;

  // Picks the register that an address names, shared by reads and writes.
  function automatic logic [2:0] reg_select(input logic [clock_gating_pkg::ADDR_W-1:0] a);
    case ({a[clock_gating_pkg::ADDR_W-1:2], 2'h0})
      clock_gating_pkg::RUN_GATE_OFF: reg_select = clock_gating_pkg::SEL_RUN;
      clock_gating_pkg::SLEEP_GATE_OFF: reg_select = clock_gating_pkg::SEL_SLEEP;
      clock_gating_pkg::DEEP_GATE_OFF: reg_select = clock_gating_pkg::SEL_DEEP;
      clock_gating_pkg::RUN_CFG_OFF: reg_select = clock_gating_pkg::SEL_CFG;
      clock_gating_pkg::IRQ_STATUS_OFF: reg_select = clock_gating_pkg::SEL_STATUS;
      clock_gating_pkg::IRQ_MASK_OFF: reg_select = clock_gating_pkg::SEL_MASK;
      default: reg_select = clock_gating_pkg::SEL_NONE;
    endcase
  endfunction

  // Merges written bytes into the old word under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = data[8*i +: 8];
      end
    end
  endfunction

  // Masks a gating word to its live bits and holds the speed at the part's limit.
  function automatic logic [31:0] gate_word(input logic [31:0] w);
    gate_word = w & clock_gating_pkg::GATE_WMASK;
    if (gate_word[clock_gating_pkg::SPEED_LSB +: 2] > MAX_SPEED) begin
      gate_word[clock_gating_pkg::SPEED_LSB +: 2] = MAX_SPEED;
    end
  endfunction

  // Write channel: address and data are taken in either order, one write at a time.
  logic wr_go;
  logic [2:0] wr_sel;
  logic [3:0] w1c;
  assign s_axi_awready_out = ce_in & ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready_out = ce_in & ~w_hold_q & ~bvalid_q;
  assign wr_go = ce_in & aw_hold_q & w_hold_q & ~bvalid_q;
  assign wr_sel = reg_select(awaddr_q);
  assign w1c = (wr_go && wr_sel == clock_gating_pkg::SEL_STATUS && wstrb_q[0]) ?
               wdata_q[3:0] : 4'h0;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= '0;
    end else if (ce_in) begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_in;
      end else if (wr_go) begin
        aw_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      w_hold_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (ce_in) begin
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata_in;
        wstrb_q <= s_axi_wstrb_in;
      end else if (wr_go) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= clock_gating_pkg::RESP_OKAY;
    end else if (ce_in) begin
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= (wr_sel == clock_gating_pkg::SEL_NONE) ?
                   clock_gating_pkg::RESP_SLVERR : clock_gating_pkg::RESP_OKAY;
      end else if (s_axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;

  // Register file: one register per power state, each with the same layout.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_gate_q <= clock_gating_pkg::GATE_RESET;
      sleep_gate_q <= clock_gating_pkg::GATE_RESET;
      deep_gate_q <= clock_gating_pkg::GATE_RESET;
      run_cfg_q <= clock_gating_pkg::CFG_RESET;
      irq_mask_q <= 4'h0;
    end else if (wr_go) begin
      case (wr_sel)
        clock_gating_pkg::SEL_RUN: run_gate_q <= gate_word(merge(run_gate_q, wdata_q, wstrb_q));
        clock_gating_pkg::SEL_SLEEP: sleep_gate_q <= gate_word(merge(sleep_gate_q, wdata_q,
                                                                     wstrb_q));
        clock_gating_pkg::SEL_DEEP: deep_gate_q <= gate_word(merge(deep_gate_q, wdata_q,
                                                                   wstrb_q));
        clock_gating_pkg::SEL_CFG: run_cfg_q <= merge(run_cfg_q, wdata_q, wstrb_q) &
                                                (32'h1 << clock_gating_pkg::AUTO_GATING_BIT);
        clock_gating_pkg::SEL_MASK: irq_mask_q <= wstrb_q[0] ? wdata_q[3:0] : irq_mask_q;
        default: irq_mask_q <= irq_mask_q;
      endcase
    end
  end

  // A fault in the same cycle as its clearing write still leaves the bit set.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_status_q <= 4'h0;
    end else if (ce_in) begin
      irq_status_q <= (irq_status_q & ~w1c) | gate.fault;
    end
  end
  assign irq_out = |(irq_status_q & irq_mask_q);

  // Read channel: one read at a time, answered one cycle after the address is taken.
  logic [2:0] rd_sel;
  logic [31:0] rd_word;
  assign s_axi_arready_out = ce_in & ~rvalid_q;
  assign rd_sel = reg_select(s_axi_araddr_in);
  assign rd_word = (rd_sel == clock_gating_pkg::SEL_RUN) ? run_gate_q :
                   (rd_sel == clock_gating_pkg::SEL_SLEEP) ? sleep_gate_q :
                   (rd_sel == clock_gating_pkg::SEL_DEEP) ? deep_gate_q :
                   (rd_sel == clock_gating_pkg::SEL_CFG) ? run_cfg_q :
                   (rd_sel == clock_gating_pkg::SEL_STATUS) ? {28'h0000000, irq_status_q} :
                   (rd_sel == clock_gating_pkg::SEL_MASK) ? {28'h0000000, irq_mask_q} :
                   32'h00000000;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= clock_gating_pkg::RESP_OKAY;
    end else if (ce_in) begin
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= (rd_sel == clock_gating_pkg::SEL_NONE) ?
                   clock_gating_pkg::RESP_SLVERR : clock_gating_pkg::RESP_OKAY;
      end else if (s_axi_rready_in) begin
        rvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;

  // Power state picks the governing register; without automatic gating run rules all.
  clock_gating_pkg::power_state_t pstate;
  logic auto_gating_select;
  logic [3:0] eff_en;
  assign pstate = clock_gating_pkg::power_state_t'(power_state_in);
  assign auto_gating_select = run_cfg_q[clock_gating_pkg::AUTO_GATING_BIT];
  assign eff_en = (auto_gating_select && pstate == clock_gating_pkg::PWR_SLEEP) ?
                  clock_gating_pkg::unit_bits(sleep_gate_q) :
                  (auto_gating_select && power_state_in[1]) ? clock_gating_pkg::unit_bits(deep_gate_q) :
                  clock_gating_pkg::unit_bits(run_gate_q);

  // Accesses are judged on the enables actually reaching the units.
  assign gate.ce = ce_in;
  assign gate.enable = unit_clk_en_out;

  genvar u;
  generate
    for (u = 0; u < clock_gating_pkg::UNITS; u++) begin : g_gate
      unit_clock_gate #(
        .RESET_EN(clock_gating_pkg::UNIT_EN_RESET[u])
      ) u_gate (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .ce_in(ce_in),
        .enable_in(eff_en[u]),
        .enable_out(unit_clk_en_out[u]),
        .gated_clk_out(gated_clk_out[u])
      );
    end
  endgenerate

  access_guard u_guard (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .gate(gate),
    .acc_valid_in(acc_valid_in),
    .acc_unit_in(acc_unit_in),
    .acc_ok_out(acc_ok_out),
    .acc_fault_out(acc_fault_out)
  );

  // The converter follows the run register's speed field, held at the limit.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      adc_rate_q <= clock_gating_pkg::SPEED_125K;
    end else if (ce_in) begin
      adc_rate_q <= run_gate_q[clock_gating_pkg::SPEED_LSB +: 2];
    end
  end
  assign adc_rate_out = adc_rate_q;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_reserved_zero: assert property (
    ((run_gate_q | sleep_gate_q | deep_gate_q) & ~clock_gating_pkg::GATE_WMASK) == 32'h0)
    else $error("reserved gating bit is set");
  a_speed_limit: assert property (
    adc_rate_out <= MAX_SPEED && run_gate_q[9:8] <= MAX_SPEED)
    else $error("converter speed above the limit");
  a_rate_follows: assert property (
    ce_in |=> adc_rate_out == $past(run_gate_q[9:8]))
    else $error("converter rate does not follow the speed field");
  a_run_governs: assert property (
    pstate == clock_gating_pkg::PWR_RUN |-> eff_en == {run_gate_q[20], run_gate_q[16],
                                                       run_gate_q[3], run_gate_q[6]})
    else $error("run register not in control while running");
  a_acg_off_run: assert property (
    !auto_gating_select |-> eff_en == {run_gate_q[20], run_gate_q[16], run_gate_q[3], run_gate_q[6]})
    else $error("low-power register used without automatic gating");
  a_deep_governs: assert property (
    auto_gating_select && pstate == clock_gating_pkg::PWR_DEEP |-> eff_en == {deep_gate_q[20],
                                           deep_gate_q[16], deep_gate_q[3], deep_gate_q[6]})
    else $error("deep-sleep register not in control");
  a_enable_tracks: assert property (
    (ce_in && $stable(eff_en)) [*2] |-> unit_clk_en_out == eff_en)
    else $error("unit clock enable does not follow its gating bit");
  a_fault_sets_irq: assert property (
    ce_in && gate.fault[clock_gating_pkg::UNIT_WATCHDOG] |=> irq_status_q[1])
    else $error("watchdog fault lost from status");
  a_write_answer: assert property (
    wr_go |=> s_axi_bvalid_out)
    else $error("write not answered");
  a_read_answer: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read not answered");
  a_gate_after_reset: assert property (
    $rose(reset_n_in) |-> run_gate_q == 32'h00000040 && sleep_gate_q == 32'h00000040)
    else $error("gating registers not at reset value");

  c_sleep_acg: cover property (auto_gating_select && pstate == clock_gating_pkg::PWR_SLEEP);
  c_deep_acg: cover property (auto_gating_select && pstate == clock_gating_pkg::PWR_DEEP);
  c_irq_raised: cover property ($rose(irq_out));
  c_speed_clamped: cover property (wr_go && wdata_q[9:8] == 2'h3);
endmodule // peripheral_clock_gating_ctl
`default_nettype wire

/* File: dv/periph_model.sv */
// Behavioural model of the gated peripherals: counts the clock edges each one receives.
`timescale 1ns/1ps
`default_nettype none
module periph_model (
  input wire logic [3:0] gated_clk_in,
  output wire logic [63:0] ticks_out
);
  for (genvar i = 0; i < 4; i++) begin : g_unit
    logic [15:0] cnt_q = 16'h0000;
    // A unit only advances while its clock arrives, so a stalled count means gated off.
    always @(posedge gated_clk_in[i]) begin
      cnt_q <= cnt_q + 16'h0001;
    end
    assign ticks_out[16*i +: 16] = cnt_q;
  end
endmodule // periph_model
`default_nettype wire

/* File: dv/peripheral_clock_gating_ctl_tb.sv */
// Self-checking bench for the peripheral clock gating controller.
`timescale 1ns/1ps
`default_nettype none
module peripheral_clock_gating_ctl_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, accv = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h00000000;
  logic [1:0] pst = 2'h0, accu = 2'h0;
  logic awr, wr, bv, arr, rv, ok, flt, irq;
  logic [1:0] br, rr, rate;
  logic [31:0] rd;
  logic [3:0] en, gclk;
  wire logic [63:0] ticks;
  int bad_count = 0;
  int compares = 0;
  logic [31:0] lfsr = 32'h00009BFF;

  always #5 clk = ~clk;

  peripheral_clock_gating_ctl u_peripheral_clock_gating_ctl (
    .clk_in(clk), .reset_n_in(rst_n), .ce_in(ce),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
    .s_axi_bresp_out(br), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre),
    .s_axi_rdata_out(rd), .s_axi_rresp_out(rr), .power_state_in(pst),
    .acc_valid_in(accv), .acc_unit_in(accu), .acc_ok_out(ok), .acc_fault_out(flt),
    .unit_clk_en_out(en), .gated_clk_out(gclk), .adc_rate_out(rate), .irq_out(irq));

  periph_model u_periph_model (.gated_clk_in(gclk), .ticks_out(ticks));

  task automatic summarize();
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Address and data are offered together and each is dropped once taken.
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    bre <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!bv && n < 100);
    bre <= 1'b0;
    chk({30'h0, br}, {30'h0, er}, "write response");
    if (n >= 100) bad_count++;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rre <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 1'b0;
    end while (!rv && n < 100);
    rre <= 1'b0;
    chk(rd, e, "read data");
    chk({30'h0, rr}, {30'h0, er}, "read response");
    if (n >= 100) bad_count++;
  endtask

  task automatic acc(input logic [1:0] u, input logic f);
    @(posedge clk);
    accv <= 1'b1;
    accu <= u;
    @(posedge clk);
    accv <= 1'b0;
    @(posedge clk);
    chk({ok, flt}, {~f, f}, "access answer");
  endtask

  // Writable bits survive, and a speed above the fastest rate is held at it.
  function automatic logic [31:0] gate_exp(input logic [31:0] d);
    gate_exp = d & clock_gating_pkg::GATE_WMASK;
    if (d[9:8] > 2'h1) gate_exp[9:8] = 2'h1;
  endfunction

  function automatic logic [3:0] en_exp(input logic [31:0] r);
    en_exp = {r[20], r[16], r[3], r[6]};
  endfunction

  function automatic logic [31:0] next_lfsr(input logic [31:0] v);
    next_lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end

  initial begin
    logic [31:0] g;
    logic [63:0] t;
    logic [3:0] e;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rchk(12'h100, 32'h00000040, 2'h0);
    rchk(12'h110, 32'h00000040, 2'h0);
    rchk(12'h120, 32'h00000040, 2'h0);
    chk(en, 4'h1, "reset enables");
    chk(rate, 2'h0, "reset rate");
    for (int u = 0; u < 4; u++) acc(u[1:0], u != 0);
    chk(irq, 1'b0, "masked irq");
    rchk(12'h140, 32'h0000000E, 2'h0);
    axw(12'h144, 32'h0000000F, 2'h0);
    chk(irq, 1'b1, "irq raised");
    axw(12'h140, 32'h0000000E, 2'h0);
    chk(irq, 1'b0, "irq cleared");
    axw(12'h110, 32'hFFFFFFFF, 2'h0);
    rchk(12'h110, 32'h00110148, 2'h0);
    axw(12'h120, 32'hFFFFFFFF, 2'h0);
    rchk(12'h120, 32'h00110148, 2'h0);
    for (int i = 0; i < 24; i++) begin
      lfsr = next_lfsr(next_lfsr(next_lfsr(lfsr)));
      g = gate_exp(lfsr);
      e = en_exp(g);
      axw(12'h100, lfsr, 2'h0);
      rchk(12'h100, g, 2'h0);
      chk(rate, g[9:8], "rate");
      chk(en, e, "enables");
      t = ticks;
      repeat (8) @(posedge clk);
      for (int k = 0; k < 4; k++) chk(ticks[16*k +: 16] != t[16*k +: 16], e[k], "clock");
      acc(lfsr[25:24], !e[lfsr[25:24]]);
    end
    axw(12'h100, 32'h00000048, 2'h0);
    axw(12'h110, 32'h00010000, 2'h0);
    axw(12'h120, 32'h00100000, 2'h0);
    for (int c = 0; c < 2; c++) begin
      axw(12'h130, c, 2'h0);
      for (int s = 0; s < 4; s++) begin
        pst <= s[1:0];
        repeat (3) @(posedge clk);
        chk(en, (c == 0 || s == 0) ? 4'h3 : (s == 1 ? 4'h4 : 4'h8), "power state");
      end
    end
    // An access while the clock enable is low must be ignored and no ready may show.
    ce <= 1'b0;
    accv <= 1'b1;
    accu <= 2'h1;
    repeat (2) @(posedge clk);
    chk({ok, flt}, 2'h0, "frozen access");
    chk(arr, 1'b0, "frozen ready");
    accv <= 1'b0;
    ce <= 1'b1;
    pst <= 2'h0;
    axw(12'h200, 32'hFFFFFFFF, 2'h2);
    rchk(12'h200, 32'h00000000, 2'h2);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    rchk(12'h100, 32'h00000040, 2'h0);
    chk(en, 4'h1, "enables after reset");
    summarize();
  end
endmodule // peripheral_clock_gating_ctl_tb
`default_nettype wire
